// [mmct_pkg.sv]
/*
  mmct_pkg: constants shared by the module management control block:
  management byte map, field positions, reset values, setting code limits
  and timing figures with their cycle counts at the 100 MHz ref clock.
  Assumes a flat 8-bit byte address space on the two-wire bus.
*/
package mmct_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // timing figures as printed, then cycle counts
  localparam int T_RESET_PULSE_US = 2;
  localparam int T_INIT_MS = 2000;
  localparam int RESET_PULSE_CYC = (T_RESET_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint INIT_CYC = (64'(T_INIT_MS) * 1000000) / CLK_PERIOD_NS;
  // two-wire bus address (7 bit)
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // byte map
  localparam logic [7:0] OFS_STATUS = 8'h02;
  localparam logic [7:0] OFS_FLAG_LINE = 8'h03;
  localparam logic [7:0] OFS_FLAG_OTHER = 8'h04;
  localparam logic [7:0] OFS_PDOWN = 8'h5D;
  localparam logic [7:0] OFS_MASK_LINE = 8'h64;
  localparam logic [7:0] OFS_MASK_OTHER = 8'h65;
  localparam logic [7:0] OFS_TX_EQ = 8'hEA;
  localparam logic [7:0] OFS_RX_EMPH = 8'hEC;
  localparam logic [7:0] OFS_RX_AMP = 8'hEE;
  // fields
  localparam int NOT_READY_BIT = 0;
  localparam int PDOWN_BIT = 0;
  localparam int NUM_FLAGS = 16;
  localparam int NUM_LANES = 4;
  // reset values
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] SETTING_RST = 16'h0000;
  // highest legal setting codes
  localparam logic [3:0] EQ_MAX = 4'hA;
  localparam logic [3:0] EMPH_MAX = 4'h7;
  localparam logic [3:0] AMP_MAX = 4'h3;
endpackage

// [mmct_hold_timer.sv]
/*
  mmct_hold_timer: saturating counter of consecutive cycles with run_i high;
  done_o rises once the run has lasted LIMIT cycles and clears with run_i.
  Assumes run_i is already on the ref clock.
*/
`timescale 1ns/1ps
module mmct_hold_timer #(
  parameter int W = 32,
  parameter logic [W-1:0] LIMIT = '1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // run and result
  input wire logic run_i,
  output logic done_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire at_limit_w = (cnt_r == LIMIT);

  assign cnt_nxt = !run_i ? '0 : (at_limit_w ? cnt_r : cnt_r + 1'b1);

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = at_limit_w && run_i;
endmodule // mmct_hold_timer

// [mmct_twi_slave.sv]
/*
  mmct_twi_slave: two-wire bus slave with an auto-incrementing byte pointer.
  First byte after a write address sets the pointer; later bytes write.
  Assumes an external pull-up; sda is driven low only (drive_n low = pull low).
*/
`timescale 1ns/1ps
module mmct_twi_slave
  import mmct_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_drive_n_o,
  // control
  input wire logic enable_i,
  // byte port
  output logic [7:0] addr_o,
  output logic wr_stb_o,
  output logic [7:0] wr_data_o,
  output logic rd_stb_o,
  input wire logic [7:0] rd_data_i,
  output logic stop_o
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_ADDR = 6'b000010, S_WACK = 6'b000100,
    S_RX = 6'b001000, S_TX = 6'b010000, S_RACK = 6'b100000
  } mmct_twi_state_type;

  mmct_twi_state_type state_r;
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_r;
  logic [7:0] ptr_r;
  logic rw_r, first_r, pull_r, ack_r, stop_r;

  // [0] is read only by [1]; edges are taken from [1] and [2]
  wire scl_w = scl_s_r[1];
  wire sda_w = sda_s_r[1];
  wire rise_w = scl_w && !scl_s_r[2];
  wire fall_w = !scl_w && scl_s_r[2];
  wire start_w = scl_w && scl_s_r[2] && !sda_w && sda_s_r[2];
  wire stop_w = scl_w && scl_s_r[2] && sda_w && !sda_s_r[2];
  wire full_w = (cnt_r == 4'h8);
  wire load_w = fall_w && ((state_r == S_WACK && rw_r) || (state_r == S_RACK && ack_r));

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= S_IDLE;
      shift_r <= 8'h00;
      cnt_r <= 4'h0;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      pull_r <= 1'b0;
      ack_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      stop_r <= stop_w;
      if (!enable_i || stop_w) begin
        state_r <= S_IDLE; // not selected: stop answering at once
        pull_r <= 1'b0;
      end else if (start_w) begin
        state_r <= S_ADDR;
        cnt_r <= 4'h0;
        pull_r <= 1'b0;
      end else if (rise_w) begin
        if (state_r == S_ADDR || state_r == S_RX) begin
          shift_r <= {shift_r[6:0], sda_w};
          cnt_r <= cnt_r + 4'h1;
        end
        if (state_r == S_RACK) begin
          ack_r <= !sda_w;
        end
      end else if (load_w) begin
        shift_r <= {rd_data_i[6:0], 1'b0};
        pull_r <= !rd_data_i[7];
        cnt_r <= 4'h1;
        ptr_r <= ptr_r + 8'h01;
        state_r <= S_TX;
      end else if (fall_w) begin
        unique case (state_r)
          S_IDLE: ;
          S_ADDR: begin
            if (full_w && shift_r[7:1] == DEV_ADDR) begin
              state_r <= S_WACK;
              rw_r <= shift_r[0];
              first_r <= !shift_r[0];
              pull_r <= 1'b1;
            end else if (full_w) begin
              state_r <= S_IDLE;
            end
          end
          S_WACK: begin
            pull_r <= 1'b0;
            cnt_r <= 4'h0;
            state_r <= S_RX;
          end
          S_RX: begin
            if (full_w) begin
              first_r <= 1'b0;
              ptr_r <= first_r ? shift_r : ptr_r + 8'h01;
              pull_r <= 1'b1;
              state_r <= S_WACK;
            end
          end
          S_TX: begin
            if (full_w) begin
              pull_r <= 1'b0;
              state_r <= S_RACK;
            end else begin
              pull_r <= !shift_r[7];
              shift_r <= {shift_r[6:0], 1'b0};
              cnt_r <= cnt_r + 4'h1;
            end
          end
          S_RACK: state_r <= S_IDLE; // master nack: wait for stop
        endcase
      end
    end
  end

  assign addr_o = ptr_r;
  assign wr_data_o = shift_r;
  assign wr_stb_o = fall_w && enable_i && !stop_w && !start_w && (state_r == S_RX) && full_w
    && !first_r;
  assign rd_stb_o = load_w && enable_i && !stop_w && !start_w;
  assign stop_o = stop_r;
  assign sda_o = 1'b0;
  assign sda_drive_n_o = !pull_r;
endmodule // mmct_twi_slave

// [mmct_core.sv]
/*
  mmct_core: management control and status of a four-lane pluggable optical
  module: reset pin filter, initialisation timer, latched clear-on-read
  flags with masks and interrupt pin, low power control and lane settings,
  all but the reset pin filter reached over the two-wire management bus.
  Assumes line condition inputs come from logic on ref_clk_i; pins do not.
*/
// Overview of operation
// R1 - amplitude code 0-3 selects output swing ranges; 4-15 are reserved
// R2 - equalization code 0-10 gives 0-10 dB in 1 dB steps; 11-15 reserved
// R3 - emphasis code 0-7 gives 0-7 dB in 1 dB steps; 8-15 reserved
// R4 - fully functional within 2000 ms of power-on or reset pin rising edge
// R5 - reset pin low longer than 2 us resets the module; host holds it so long
// R6 - serial bus answers within 2000 ms after power-on
// R7 - within 2000 ms clear not-ready bit 0 of byte 2 and assert interrupt
// R8 - low power select high lowers power within 100 us
// R9 - interrupt pin goes low within 200 ms of a triggering condition
// R10 - flags clear on read; interrupt releases within 500 us of that stop bit
// R11 - entering loss of signal sets its flag and interrupt within 100 ms
// R12 - entering transmit fault sets its flag and interrupt within 200 ms
// R13 - any other flag condition sets its flag and interrupt within 200 ms
// R14 - mask set inhibits its interrupt, mask cleared restores it, within 100 ms
// R15 - bus answers within 100 us of select low, stops within 100 us of release
// R16 - power-down override set lowers power in 100 ms, cleared restores in 300 ms
// R17 - write-triggered timing starts at the clock fall after the write stop bit
// R18 - a reserved setting code is ignored and the previous setting kept
`timescale 1ns/1ps
module mmct_core
  import mmct_pkg::*;
#(
  parameter longint INIT_CYCLES = INIT_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // host pins
  input wire logic module_reset_n_i,
  input wire logic module_select_n_i,
  input wire logic low_power_select_i,
  output logic interrupt_out_n_o,
  // management bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_drive_n_o,
  // line conditions
  input wire logic [NUM_LANES-1:0] rx_los_i,
  input wire logic [NUM_LANES-1:0] tx_fault_i,
  input wire logic [7:0] other_cond_i,
  // module controls
  output logic module_ready_o,
  output logic low_power_o,
  output logic [15:0] tx_eq_o,
  output logic [15:0] rx_emph_o,
  output logic [15:0] rx_amp_o
);
  // pin synchronisers
  // only the second flop of each pair feeds logic
  logic [1:0] rst_s_r;
  logic [1:0] sel_s_r;
  logic [1:0] lp_s_r;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s_r <= 2'b11;
      sel_s_r <= 2'b11;
      lp_s_r <= 2'b00;
    end else begin
      rst_s_r <= {rst_s_r[0], module_reset_n_i};
      sel_s_r <= {sel_s_r[0], module_select_n_i};
      lp_s_r <= {lp_s_r[0], low_power_select_i};
    end
  end

  // reset pin filter and initialisation timer
  logic mod_reset_w;
  logic ready_w;
  logic ready_d_r;

  // a glitch shorter than the minimum pulse never resets the module
  mmct_hold_timer #(
    .W(16),
    .LIMIT(16'(RESET_PULSE_CYC))
  ) u_reset_filter (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .run_i(!rst_s_r[1]),
    .done_o(mod_reset_w)
  ); // see R5

  // restarts on power-on and on release of a filtered reset
  mmct_hold_timer #(
    .W(32),
    .LIMIT(32'(INIT_CYCLES))
  ) u_init_timer (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .run_i(!mod_reset_w),
    .done_o(ready_w)
  ); // see R4

  // management bus slave
  logic [7:0] addr_w;
  logic wr_stb_w;
  logic [7:0] wr_data_w;
  logic rd_stb_w;
  logic [7:0] rd_data_w;
  logic stop_w;
  // select is a level: a deselect mid-frame drops the slave to idle
  wire bus_en_w = !sel_s_r[1] && !mod_reset_w; // see R15, R6

  mmct_twi_slave u_twi (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_drive_n_o(sda_drive_n_o),
    .enable_i(bus_en_w),
    .addr_o(addr_w),
    .wr_stb_o(wr_stb_w),
    .wr_data_o(wr_data_w),
    .rd_stb_o(rd_stb_w),
    .rd_data_i(rd_data_w),
    .stop_o(stop_w)
  );

  // write and read decode
  wire wr_mask_lo_w = wr_stb_w && addr_w == OFS_MASK_LINE;
  wire wr_mask_hi_w = wr_stb_w && addr_w == OFS_MASK_OTHER;
  wire wr_pdown_w = wr_stb_w && addr_w == OFS_PDOWN;
  wire rd_flag_lo_w = rd_stb_w && addr_w == OFS_FLAG_LINE;
  wire rd_flag_hi_w = rd_stb_w && addr_w == OFS_FLAG_OTHER;
  wire rd_status_w = rd_stb_w && addr_w == OFS_STATUS;

  // flags, masks and interrupt
  logic [NUM_FLAGS-1:0] flag_r;
  logic [NUM_FLAGS-1:0] cond_d_r;
  logic [NUM_FLAGS-1:0] clr_pend_r;
  logic [NUM_FLAGS-1:0] mask_r;
  logic ready_evt_r;
  logic ready_clr_pend_r;
  logic irq_n_r;
  logic pdown_r;
  logic low_power_r;
  wire [NUM_FLAGS-1:0] cond_w = {other_cond_i, tx_fault_i, rx_los_i};
  wire [NUM_FLAGS-1:0] cond_rise_w = cond_w & ~cond_d_r;
  wire [NUM_FLAGS-1:0] rd_clr_w = {{8{rd_flag_hi_w}}, {8{rd_flag_lo_w}}};
  wire [NUM_FLAGS-1:0] seen_clr_w = rd_clr_w & flag_r;
  wire [NUM_FLAGS-1:0] mask_nxt_w = wr_mask_lo_w ? {mask_r[15:8], wr_data_w} :
                                    wr_mask_hi_w ? {wr_data_w, mask_r[7:0]} : mask_r;
  wire ready_rise_w = ready_w && !ready_d_r;

  // a read marks only the flags it saw set, so a condition entered before
  // the stop bit is not lost; the clear lands at the stop bit
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clr_pend_r <= '0;
      ready_clr_pend_r <= 1'b0;
    end else begin
      clr_pend_r <= (stop_w || mod_reset_w) ? '0 : (clr_pend_r | seen_clr_w);
      ready_clr_pend_r <= (stop_w || mod_reset_w) ? 1'b0 : (ready_clr_pend_r | rd_status_w);
    end
  end

  // flags set on entering a condition; a set in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          flag_r[gi] <= 1'b0;
          cond_d_r[gi] <= 1'b0;
        end else if (mod_reset_w) begin
          flag_r[gi] <= 1'b0;
          cond_d_r[gi] <= 1'b0;
        end else begin
          cond_d_r[gi] <= cond_w[gi];
          if (cond_rise_w[gi]) begin
            flag_r[gi] <= 1'b1; // see R11, R12, R13
          end else if (stop_w && clr_pend_r[gi]) begin
            flag_r[gi] <= 1'b0; // see R10
          end
        end
      end
    end
  endgenerate

  // masks and power-down override take effect on the byte write, ahead of the stop bit
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_r <= MASK_RST;
      pdown_r <= 1'b0;
    end else if (mod_reset_w) begin
      mask_r <= MASK_RST;
      pdown_r <= 1'b0;
    end else begin
      mask_r <= mask_nxt_w; // see R14, R17
      if (wr_pdown_w) begin
        pdown_r <= wr_data_w[PDOWN_BIT]; // see R16, R17
      end
    end
  end

  // init-done event raises the interrupt until status byte is read
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_d_r <= 1'b0;
      ready_evt_r <= 1'b0;
    end else begin
      ready_d_r <= ready_w;
      if (mod_reset_w) begin
        ready_evt_r <= 1'b0;
      end else if (ready_rise_w) begin
        ready_evt_r <= 1'b1; // see R7
      end else if (stop_w && ready_clr_pend_r) begin
        ready_evt_r <= 1'b0;
      end
    end
  end

  // one cycle from any flag, mask or clear change to the pin
  // the init event bypasses the masks
  wire irq_w = |(flag_r & ~mask_r) || ready_evt_r;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_n_r <= 1'b1;
      low_power_r <= 1'b0;
    end else begin
      irq_n_r <= !irq_w; // see R9, R10, R14
      low_power_r <= lp_s_r[1] || pdown_r; // see R8, R16
    end
  end

  // lane settings: each nibble is checked on its own
  // a reserved nibble keeps its old code; legal nibbles of the byte still land
  logic [15:0] eq_r;
  logic [15:0] emph_r;
  logic [15:0] amp_r;
  wire [15:0] eq_cand_w = (addr_w == OFS_TX_EQ) ? {wr_data_w, eq_r[7:0]} :
                          {eq_r[15:8], wr_data_w};
  wire [15:0] emph_cand_w = (addr_w == OFS_RX_EMPH) ? {wr_data_w, emph_r[7:0]} :
                            {emph_r[15:8], wr_data_w};
  wire [15:0] amp_cand_w = (addr_w == OFS_RX_AMP) ? {wr_data_w, amp_r[7:0]} :
                           {amp_r[15:8], wr_data_w};
  wire wr_eq_w = wr_stb_w && addr_w[7:1] == OFS_TX_EQ[7:1];
  wire wr_emph_w = wr_stb_w && addr_w[7:1] == OFS_RX_EMPH[7:1];
  wire wr_amp_w = wr_stb_w && addr_w[7:1] == OFS_RX_AMP[7:1];

  generate
    for (gi = 0; gi < NUM_LANES; gi++) begin : g_lane
      wire [3:0] eq_c_w = eq_cand_w[gi*4 +: 4];
      wire [3:0] emph_c_w = emph_cand_w[gi*4 +: 4];
      wire [3:0] amp_c_w = amp_cand_w[gi*4 +: 4];
      always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          eq_r[gi*4 +: 4] <= SETTING_RST[gi*4 +: 4];
          emph_r[gi*4 +: 4] <= SETTING_RST[gi*4 +: 4];
          amp_r[gi*4 +: 4] <= SETTING_RST[gi*4 +: 4];
        end else if (mod_reset_w) begin
          eq_r[gi*4 +: 4] <= SETTING_RST[gi*4 +: 4];
          emph_r[gi*4 +: 4] <= SETTING_RST[gi*4 +: 4];
          amp_r[gi*4 +: 4] <= SETTING_RST[gi*4 +: 4];
        end else begin
          if (wr_eq_w && eq_c_w <= EQ_MAX) begin
            eq_r[gi*4 +: 4] <= eq_c_w; // see R2, R18
          end
          if (wr_emph_w && emph_c_w <= EMPH_MAX) begin
            emph_r[gi*4 +: 4] <= emph_c_w; // see R3, R18
          end
          if (wr_amp_w && amp_c_w <= AMP_MAX) begin
            amp_r[gi*4 +: 4] <= amp_c_w; // see R1, R18
          end
        end
      end
    end
  endgenerate

  // read mux; unmapped bytes read as zero
  wire [7:0] status_w = 8'(!ready_w) << NOT_READY_BIT; // see R7
  assign rd_data_w =
    (addr_w == OFS_STATUS) ? status_w :
    (addr_w == OFS_FLAG_LINE) ? flag_r[7:0] :
    (addr_w == OFS_FLAG_OTHER) ? flag_r[15:8] :
    (addr_w == OFS_MASK_LINE) ? mask_r[7:0] :
    (addr_w == OFS_MASK_OTHER) ? mask_r[15:8] :
    (addr_w == OFS_PDOWN) ? (8'(pdown_r) << PDOWN_BIT) :
    (addr_w == OFS_TX_EQ) ? eq_r[15:8] :
    (addr_w == OFS_TX_EQ + 8'h01) ? eq_r[7:0] :
    (addr_w == OFS_RX_EMPH) ? emph_r[15:8] :
    (addr_w == OFS_RX_EMPH + 8'h01) ? emph_r[7:0] :
    (addr_w == OFS_RX_AMP) ? amp_r[15:8] :
    (addr_w == OFS_RX_AMP + 8'h01) ? amp_r[7:0] : 8'h00;

  assign interrupt_out_n_o = irq_n_r;
  assign module_ready_o = ready_d_r;
  assign low_power_o = low_power_r;
  assign tx_eq_o = eq_r;
  assign rx_emph_o = emph_r;
  assign rx_amp_o = amp_r;
endmodule // mmct_core

// [mmct_core_assertions.sv]
/*
  mmct_core_assertions: timing checks on the pins of mmct_core.
  Assumes one ref clock with an async active-low reset, bound below.
*/
`timescale 1ns/1ps
module mmct_core_assertions
  import mmct_pkg::*;
#(
  parameter longint INIT_CYCLES = INIT_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // host pins
  input wire logic module_reset_n_i,
  input wire logic module_select_n_i,
  input wire logic low_power_select_i,
  input wire logic interrupt_out_n_o,
  input wire logic sda_drive_n_o,
  // line conditions
  input wire logic [NUM_LANES-1:0] rx_los_i,
  input wire logic [NUM_LANES-1:0] tx_fault_i,
  // module controls
  input wire logic module_ready_o,
  input wire logic low_power_o,
  input wire logic [15:0] tx_eq_o,
  input wire logic [15:0] rx_emph_o,
  input wire logic [15:0] rx_amp_o
);
  logic [7:0] low_cnt_r;
  logic [31:0] init_cnt_r;
  logic codes_ok;

  function automatic logic nib_ok(input logic [15:0] v, input logic [3:0] mx);
    nib_ok = (v[15:12] <= mx) && (v[11:8] <= mx) && (v[7:4] <= mx) && (v[3:0] <= mx);
  endfunction

  assign codes_ok = nib_ok(tx_eq_o, EQ_MAX) && nib_ok(rx_emph_o, EMPH_MAX) &&
    nib_ok(rx_amp_o, AMP_MAX);

  // low-pin counter saturates so a long hold never wraps back into the short zone
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      low_cnt_r <= 8'h00;
      init_cnt_r <= 32'h0;
    end else begin
      low_cnt_r <= module_reset_n_i ? 8'h00 : low_cnt_r + {7'h00, low_cnt_r != 8'hFF};
      init_cnt_r <= (!module_reset_n_i || module_ready_o) ? 32'h0 : init_cnt_r + 32'h1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_init_bound;
    64'(init_cnt_r) <= INIT_CYCLES + 12;
  endproperty
  a_init_bound: assert property (p_init_bound) else $error("init took too long");
  property p_init_irq;
    $rose(module_ready_o) |-> ##[0:3] !interrupt_out_n_o;
  endproperty
  a_init_irq: assert property (p_init_irq) else $error("no irq at ready");
  property p_lp_pin;
    $rose(low_power_select_i) |-> ##[1:6] low_power_o;
  endproperty
  a_lp_pin: assert property (p_lp_pin) else $error("low power late");
  property p_los_irq;
    $rose(|rx_los_i) && module_ready_o |-> ##[1:4] !interrupt_out_n_o;
  endproperty
  a_los_irq: assert property (p_los_irq) else $error("los irq late");
  property p_fault_irq;
    $rose(|tx_fault_i) && module_ready_o |-> ##[1:4] !interrupt_out_n_o;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("fault irq late");
  property p_desel;
    module_select_n_i [*8] |-> sda_drive_n_o;
  endproperty
  a_desel: assert property (p_desel) else $error("bus driven unselected");
  property p_filt_long;
    low_cnt_r >= 8'd215 |-> !module_ready_o && sda_drive_n_o;
  endproperty
  a_filt_long: assert property (p_filt_long) else $error("reset pin ignored");
  property p_filt_short;
    module_ready_o && !module_reset_n_i && low_cnt_r < 8'd190 |=> module_ready_o;
  endproperty
  a_filt_short: assert property (p_filt_short) else $error("short pulse reset");
  property p_codes;
    codes_ok;
  endproperty
  a_codes: assert property (p_codes) else $error("reserved code applied");
endmodule // mmct_core_assertions

bind mmct_core mmct_core_assertions #(.INIT_CYCLES(INIT_CYCLES)) mmct_core_assertions_inst (
  .ref_clk_i, .rstn_i, .module_reset_n_i, .module_select_n_i, .low_power_select_i,
  .interrupt_out_n_o, .sda_drive_n_o, .rx_los_i, .tx_fault_i, .module_ready_o,
  .low_power_o, .tx_eq_o, .rx_emph_o, .rx_amp_o);

// [mmct_host_model.sv]
/*
  mmct_host_model: host side of the two-wire management bus, with tasks.
  Assumes a pull-up on both lines; the host only pulls low or releases.
*/
`timescale 1ns/1ps
module mmct_host_model (
  // clock
  input wire logic ref_clk_i,
  // bus pins
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_drive_n_o
);
  // lines released between frames, so the pull-up holds them high
  initial begin
    scl_o = 1'b1;
    sda_drive_n_o = 1'b1;
  end

  // six clocks a phase, above the three the slave synchroniser needs
  task automatic half;
    repeat (6) @(negedge ref_clk_i);
  endtask

  task automatic bit_io(input logic v, output logic r);
    sda_drive_n_o = v;
    half();
    scl_o = 1'b1;
    half();
    r = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic start;
    sda_drive_n_o = 1'b1;
    half();
    scl_o = 1'b1;
    half();
    sda_drive_n_o = 1'b0;
    half();
    scl_o = 1'b0;
  endtask

  task automatic stop;
    sda_drive_n_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_drive_n_o = 1'b1;
    half();
  endtask

  task automatic xfer(input logic [7:0] wb, input logic mack, output logic [7:0] rb,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(wb[i], rb[i]);
    bit_io(mack, ack);
  endtask
endmodule // mmct_host_model

// [mmct_core_tb.sv]
/*
  mmct_core_tb: self-checking bench for mmct_core driven over the two-wire bus.
  Assumes mmct_host_model as bus host and a shortened init count of 50.
*/
`timescale 1ns/1ps
module mmct_core_tb
  import mmct_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic module_reset_n = 1'b1;
  logic module_select_n = 1'b0;
  logic low_power_select = 1'b0;
  logic [15:0] cond = 16'h0000;
  logic [3:0] mx_t [3] = '{EQ_MAX, EMPH_MAX, AMP_MAX};
  wire scl, sda, host_dn, core_sda, core_dn, irq_n, ready, lp;
  wire [15:0] eq, emph, amp;
  wire [47:0] all_codes = {eq, emph, amp};
  int failures = 0;
  int n_compared = 0;

  assign sda = host_dn & (core_dn | core_sda);
  always #5 ref_clk_i = ~ref_clk_i;

  mmct_core #(.INIT_CYCLES(50)) mmct_core_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .module_reset_n_i(module_reset_n), .module_select_n_i(module_select_n),
    .low_power_select_i(low_power_select), .interrupt_out_n_o(irq_n), .scl_i(scl),
    .sda_i(sda), .sda_o(core_sda), .sda_drive_n_o(core_dn), .rx_los_i(cond[3:0]),
    .tx_fault_i(cond[7:4]), .other_cond_i(cond[15:8]), .module_ready_o(ready),
    .low_power_o(lp), .tx_eq_o(eq), .rx_emph_o(emph), .rx_amp_o(amp));
  mmct_host_model mmct_host_model_inst (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
    .sda_drive_n_o(host_dn));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic wait_ready;
    for (int n = 0; n < 100 && ready !== 1'b1; n++) wait_clk(1);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input logic nack);
    logic [7:0] rb;
    logic ack;
    mmct_host_model_inst.start();
    mmct_host_model_inst.xfer({DEV_ADDR, 1'b0}, 1'b1, rb, ack);
    chk_bit(ack, nack);
    if (!ack) begin
      mmct_host_model_inst.xfer(ofs, 1'b1, rb, ack);
      mmct_host_model_inst.xfer(d, 1'b1, rb, ack);
    end
    mmct_host_model_inst.stop();
  endtask

  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic ack;
    mmct_host_model_inst.start();
    mmct_host_model_inst.xfer({DEV_ADDR, 1'b0}, 1'b1, d, ack);
    mmct_host_model_inst.xfer(ofs, 1'b1, d, ack);
    mmct_host_model_inst.start();
    mmct_host_model_inst.xfer({DEV_ADDR, 1'b1}, 1'b1, d, ack);
    mmct_host_model_inst.xfer(8'hFF, 1'b1, d, ack);
    mmct_host_model_inst.stop();
  endtask

  task automatic final_report;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge ref_clk_i);
    failures++;
    final_report();
  end

  initial begin
    logic [7:0] b;
    logic [7:0] fo;
    logic [15:0] expv;
    logic [3:0] cv;
    int src [3];
    src = '{2, 5, 15};
    wait_clk(6);
    rstn_i = 1'b1;
    chk(eq, SETTING_RST);
    chk(emph, SETTING_RST);
    chk(amp, SETTING_RST);
    chk_bit(irq_n, 1'b1);
    wait_ready();
    chk_bit(ready, 1'b1);
    wait_clk(4);
    chk_bit(irq_n, 1'b0);
    rd(OFS_STATUS, b);
    chk_bit(b[NOT_READY_BIT], 1'b0);
    wait_clk(8);
    chk_bit(irq_n, 1'b1);
    $display("test init done");
    for (int r = 0; r < 3; r++) begin
      expv = SETTING_RST;
      for (int c = 0; c < 16; c++) begin
        cv = 4'(c);
        if (cv <= mx_t[r]) expv = {cv, cv, SETTING_RST[7:0]};
        wr(OFS_TX_EQ + 8'(2 * r), {cv, cv}, 1'b0);
        chk(all_codes[47 - 16 * r -: 16], expv);
      end
      wr(OFS_TX_EQ + 8'(2 * r + 1), 8'h10, 1'b0);
      chk(all_codes[47 - 16 * r -: 16], {expv[15:8], 8'h10});
      rd(OFS_TX_EQ + 8'(2 * r), b);
      chk({8'h00, b}, {8'h00, expv[15:8]});
    end
    wr(8'h80, 8'h55, 1'b0);
    rd(8'h80, b);
    chk({8'h00, b}, 16'h0000);
    $display("test settings done");
    for (int k = 0; k < 3; k++) begin
      fo = src[k] < 8 ? OFS_FLAG_LINE : OFS_FLAG_OTHER;
      cond[src[k]] = 1'b1;
      wait_clk(4);
      chk_bit(irq_n, 1'b0);
      rd(fo, b);
      chk({8'h00, b}, 16'h0001 << (src[k] % 8));
      wait_clk(8);
      chk_bit(irq_n, 1'b1);
      rd(fo, b);
      chk({8'h00, b}, 16'h0000);
      cond[src[k]] = 1'b0;
    end
    $display("test flags done");
    wr(OFS_MASK_OTHER, 8'h01, 1'b0);
    cond[8] = 1'b1;
    wait_clk(8);
    chk_bit(irq_n, 1'b1);
    wr(OFS_MASK_OTHER, 8'h00, 1'b0);
    wait_clk(2);
    chk_bit(irq_n, 1'b0);
    rd(OFS_FLAG_OTHER, b);
    chk({8'h00, b}, 16'h0001);
    cond[8] = 1'b0;
    $display("test mask done");
    low_power_select = 1'b1;
    wait_clk(6);
    chk_bit(lp, 1'b1);
    low_power_select = 1'b0;
    wait_clk(6);
    chk_bit(lp, 1'b0);
    wr(OFS_PDOWN, 8'h01, 1'b0);
    chk_bit(lp, 1'b1);
    rd(OFS_PDOWN, b);
    chk({8'h00, b}, 16'h0001 << PDOWN_BIT);
    wr(OFS_PDOWN, 8'h00, 1'b0);
    chk_bit(lp, 1'b0);
    $display("test power done");
    module_select_n = 1'b1;
    wait_clk(6);
    wr(OFS_MASK_LINE, 8'hFF, 1'b1);
    module_select_n = 1'b0;
    wait_clk(4);
    rd(OFS_MASK_LINE, b);
    chk({8'h00, b}, 16'h0000);
    $display("test select done");
    // a 1.5 us low breaks the host's minimum on purpose and must be ignored
    module_reset_n = 1'b0;
    wait_clk(150);
    module_reset_n = 1'b1;
    wait_clk(8);
    chk_bit(ready, 1'b1);
    chk(eq, {EQ_MAX, EQ_MAX, 8'h10});
    module_reset_n = 1'b0;
    wait_clk(250);
    chk_bit(ready, 1'b0);
    chk(eq, SETTING_RST);
    module_reset_n = 1'b1;
    wait_ready();
    chk_bit(ready, 1'b1);
    $display("test reset pin done");
    final_report();
  end
endmodule // mmct_core_tb
